// file: include/opcode_decoder_pkg.sv
// Purpose: shared constants and types for the opcode and addressing decoder
// Assumes: 8-bit opcode bytes, 16-bit address space
// Notes: COPY_EXTRA and WAIT_STACK_EXTRA are extra cycles after the opcode fetch, VECTOR_CYCLES is the vector fetch length
package opcode_decoder_pkg;
  // prebytes that select opcode pages 2, 3 and 4
  localparam logic [7:0] PRE_PAGE2 = 8'h18;
  localparam logic [7:0] PRE_PAGE3 = 8'h1A;
  localparam logic [7:0] PRE_PAGE4 = 8'hCD;
  // opcodes handled specially
  localparam logic [7:0] OP_COPY_TO_SP = 8'h35;
  localparam logic [7:0] OP_WAIT = 8'h3E;
  localparam logic [7:0] OP_BRANCH_ALWAYS = 8'h20;
  localparam logic [7:0] OP_BRANCH_NEVER = 8'h21;
  localparam logic [7:0] OP_BRANCH_SUB = 8'h8D;
  // page codes
  localparam logic [1:0] PAGE_1 = 2'h0;
  localparam logic [1:0] PAGE_2 = 2'h1;
  localparam logic [1:0] PAGE_3 = 2'h2;
  localparam logic [1:0] PAGE_4 = 2'h3;
  // cycle counts after the opcode fetch, and the length of the vector fetch
  localparam logic [3:0] COPY_EXTRA = 4'h2;
  localparam logic [3:0] WAIT_STACK_EXTRA = 4'hB;
  localparam logic [3:0] VECTOR_CYCLES = 4'h2;
  // values after reset, and the default interrupt vector
  localparam logic [15:0] RESET_PC = 16'h0000;
  localparam logic [15:0] RESET_SP = 16'h0000;
  localparam logic [15:0] DEFAULT_IRQ_VECTOR = 16'hFFF2;
  // addressing modes
  typedef enum logic [2:0] {
    IMPLIED_MODE = 3'h0,
    IMMEDIATE_MODE = 3'h1,
    DIRECT_MODE = 3'h2,
    FULL_ADDRESS_MODE = 3'h3,
    X_INDEXED_MODE = 3'h4,
    PC_RELATIVE_MODE = 3'h5
  } mode_e;
  // sequencer states, one-hot
  typedef enum logic [7:0] {
    S_OPCODE = 8'h01,
    S_OPERAND1 = 8'h02,
    S_OPERAND2 = 8'h04,
    S_MASK = 8'h08,
    S_BIT_READ = 8'h10,
    S_EXEC = 8'h20,
    S_WAIT = 8'h40,
    S_VECTOR = 8'h80
  } state_e;
endpackage : opcode_decoder_pkg

// file: logic/opcode_addressing_decoder.sv
// Purpose: fetch opcodes and operands, form effective addresses, branch
// Assumes: memData holds the byte at memAddr within the same cycle
// Notes: instrDone pulses one cycle after the last bus cycle, eaValid one cycle after the last address byte, or after the mask byte for bit ops
`timescale 1ns/1ps
`default_nettype none
// Function
// RULE_01 - opcode 35 loads SP with X-1, 3 cycles
// RULE_02 - prebyte 18 then 35 loads SP with Y-1, 4 cycles
// RULE_03 - wait: 12 stack, n idle, 2 vector
// RULE_04 - direct address high byte forced zero
// RULE_05 - direct skips the high address fetch
// RULE_06 - zero page internal or external by setting
// RULE_07 - indexed adds unsigned offset to X or Y
// RULE_08 - branch offset added only when condition true
// RULE_09 - signed offset relative to following address
// RULE_10 - immediate operand follows opcode directly
// RULE_11 - wide immediate fetched high byte first
// RULE_12 - extended address two bytes, high first
// RULE_13 - pages 2 to 4 only after prebyte
// RULE_14 - inherent ops fetch no operand bytes
// RULE_15 - bit ops carry an 8-bit mask operand
// RULE_16 - high nibble selects accumulator and mode; the code decodes only the mode and selects no accumulator
module opcode_addressing_decoder #(
  parameter logic [15:0] IRQ_VECTOR = opcode_decoder_pkg::DEFAULT_IRQ_VECTOR
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] memData,
  input wire logic [15:0] xIn,
  input wire logic [15:0] yIn,
  input wire logic branchCond,
  input wire logic irqPending,
  input wire logic zeroPageInternalEn,
  output logic [15:0] memAddr,
  output logic memRead,
  output logic [7:0] opcode,
  output logic [1:0] page,
  output opcode_decoder_pkg::mode_e mode,
  output logic [15:0] operand,
  output logic [15:0] effectiveAddress,
  output logic eaValid,
  output logic [7:0] mask,
  output logic [15:0] spOut,
  output logic spLoad,
  output logic [15:0] pcOut,
  output logic instrDone,
  output logic waitIdle,
  output logic zeroPageInternal
);
  // the vector is read as two bytes, so it must not wrap
  if (IRQ_VECTOR == 16'hFFFF) begin : g_vec_check
    $error("IRQ_VECTOR must leave room for two bytes");
  end

  // mode from the opcode byte, by column
  function automatic opcode_decoder_pkg::mode_e modeOf(input logic [7:0] b);
    logic [3:0] lo;
    lo = b[3:0];
    unique case (b[7:4])
      4'h1: modeOf = (lo >= 4'hC) ? opcode_decoder_pkg::X_INDEXED_MODE :
                     (lo >= 4'h2 && lo <= 4'h5) ? opcode_decoder_pkg::DIRECT_MODE :
                     opcode_decoder_pkg::IMPLIED_MODE;
      4'h2: modeOf = opcode_decoder_pkg::PC_RELATIVE_MODE;
      4'h6, 4'hA, 4'hE: modeOf = opcode_decoder_pkg::X_INDEXED_MODE;
      4'h7, 4'hB, 4'hF: modeOf = opcode_decoder_pkg::FULL_ADDRESS_MODE;
      4'h9, 4'hD: modeOf = opcode_decoder_pkg::DIRECT_MODE;
      4'h8, 4'hC: modeOf = (b == opcode_decoder_pkg::OP_BRANCH_SUB) ?
                     opcode_decoder_pkg::PC_RELATIVE_MODE :
                     (lo == 4'hF || lo == 4'hD) ? opcode_decoder_pkg::IMPLIED_MODE :
                     opcode_decoder_pkg::IMMEDIATE_MODE;
      default: modeOf = opcode_decoder_pkg::IMPLIED_MODE;
    endcase
  endfunction : modeOf

  opcode_decoder_pkg::state_e st_r, st_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic waitOp_r, waitOp_nxt;
  logic wide_r, wide_nxt;
  logic bitOp_r, bitOp_nxt;
  logic bitTest_r, bitTest_nxt;
  logic bitSet_r, bitSet_nxt;
  logic bitCond_r, bitCond_nxt;
  logic [15:0] addr_nxt, pc_nxt, opr_nxt, ea_nxt, sp_nxt;
  logic [7:0] opc_nxt, mask_nxt;
  logic [1:0] page_nxt;
  opcode_decoder_pkg::mode_e mode_nxt;
  logic eaValid_nxt, done_nxt, spLoad_nxt, eaReady;

  // decode of the byte on the bus
  wire [3:0] lo = memData[3:0];
  wire isPrefix = (page == opcode_decoder_pkg::PAGE_1) &&
    (memData == opcode_decoder_pkg::PRE_PAGE2 || memData == opcode_decoder_pkg::PRE_PAGE3 ||
     memData == opcode_decoder_pkg::PRE_PAGE4); // RULE_13
  wire [1:0] prefixPage = (memData == opcode_decoder_pkg::PRE_PAGE2) ? opcode_decoder_pkg::PAGE_2 :
    (memData == opcode_decoder_pkg::PRE_PAGE3) ? opcode_decoder_pkg::PAGE_3 :
    opcode_decoder_pkg::PAGE_4;
  wire opcode_decoder_pkg::mode_e byteMode = modeOf(memData); // RULE_16
  wire isWide = (lo == 4'h3) || (lo == 4'hC) || (lo == 4'hE);
  wire isBit = (memData[7:4] == 4'h1) && ((lo >= 4'h2 && lo <= 4'h5) || lo >= 4'hC);
  wire isBitTest = (lo == 4'h2) || (lo == 4'h3) || (lo == 4'hE) || (lo == 4'hF);
  wire isBitSet = (lo == 4'h2) || (lo == 4'h4) || (lo == 4'hC) || (lo == 4'hE);
  wire useY = (page == opcode_decoder_pkg::PAGE_2) || (page == opcode_decoder_pkg::PAGE_4);
  wire [15:0] idxVal = useY ? yIn : xIn;
  wire [15:0] pcStep = pcOut + 16'h0001;
  wire [15:0] relTarget = pcStep + {{8{memData[7]}}, memData}; // RULE_09
  wire taken = bitTest_r ? bitCond_r :
    (opcode == opcode_decoder_pkg::OP_BRANCH_ALWAYS || opcode == opcode_decoder_pkg::OP_BRANCH_SUB) ? 1'b1 :
    (opcode == opcode_decoder_pkg::OP_BRANCH_NEVER) ? 1'b0 : branchCond;
  wire memRead_nxt = !(st_nxt == opcode_decoder_pkg::S_EXEC || st_nxt == opcode_decoder_pkg::S_WAIT);
  wire zp_nxt = eaValid_nxt ? (ea_nxt[15:8] == 8'h00 && zeroPageInternalEn) : zeroPageInternal;

  // sequencer next state
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    waitOp_nxt = waitOp_r;
    wide_nxt = wide_r;
    bitOp_nxt = bitOp_r;
    bitTest_nxt = bitTest_r;
    bitSet_nxt = bitSet_r;
    bitCond_nxt = bitCond_r;
    addr_nxt = memAddr;
    pc_nxt = pcOut;
    opr_nxt = operand;
    ea_nxt = effectiveAddress;
    sp_nxt = spOut;
    opc_nxt = opcode;
    mask_nxt = mask;
    page_nxt = page;
    mode_nxt = mode;
    eaValid_nxt = 1'b0;
    done_nxt = 1'b0;
    spLoad_nxt = 1'b0;
    eaReady = 1'b0;
    unique case (st_r)
      opcode_decoder_pkg::S_OPCODE: begin
        pc_nxt = pcStep;
        addr_nxt = pcStep;
        if (isPrefix) begin
          page_nxt = prefixPage; // RULE_13
        end else begin
          opc_nxt = memData;
          mode_nxt = byteMode;
          wide_nxt = isWide;
          bitOp_nxt = isBit;
          bitTest_nxt = isBit && isBitTest;
          bitSet_nxt = isBitSet;
          if (byteMode != opcode_decoder_pkg::IMPLIED_MODE) begin
            st_nxt = opcode_decoder_pkg::S_OPERAND1;
          end else if (memData == opcode_decoder_pkg::OP_COPY_TO_SP &&
                       page == opcode_decoder_pkg::PAGE_1) begin
            sp_nxt = xIn - 16'h0001; // RULE_01
            cnt_nxt = opcode_decoder_pkg::COPY_EXTRA;
            st_nxt = opcode_decoder_pkg::S_EXEC;
          end else if (memData == opcode_decoder_pkg::OP_COPY_TO_SP &&
                       page == opcode_decoder_pkg::PAGE_2) begin
            sp_nxt = yIn - 16'h0001; // RULE_02
            cnt_nxt = opcode_decoder_pkg::COPY_EXTRA;
            st_nxt = opcode_decoder_pkg::S_EXEC;
          end else if (memData == opcode_decoder_pkg::OP_WAIT &&
                       page == opcode_decoder_pkg::PAGE_1) begin
            cnt_nxt = opcode_decoder_pkg::WAIT_STACK_EXTRA; // RULE_03
            waitOp_nxt = 1'b1;
            st_nxt = opcode_decoder_pkg::S_EXEC;
          end else begin
            done_nxt = 1'b1; // RULE_14
          end
        end
      end
      opcode_decoder_pkg::S_OPERAND1: begin
        pc_nxt = pcStep;
        addr_nxt = pcStep;
        st_nxt = opcode_decoder_pkg::S_OPCODE;
        unique case (mode)
          opcode_decoder_pkg::IMMEDIATE_MODE: begin
            if (wide_r) begin
              opr_nxt = {memData, 8'h00}; // RULE_11
              st_nxt = opcode_decoder_pkg::S_OPERAND2;
            end else begin
              opr_nxt = {8'h00, memData}; // RULE_10
              done_nxt = 1'b1;
            end
          end
          opcode_decoder_pkg::DIRECT_MODE: begin
            ea_nxt = {8'h00, memData}; // RULE_04
            eaReady = 1'b1; // RULE_05
          end
          opcode_decoder_pkg::FULL_ADDRESS_MODE: begin
            opr_nxt = {memData, 8'h00}; // RULE_12
            st_nxt = opcode_decoder_pkg::S_OPERAND2;
          end
          opcode_decoder_pkg::X_INDEXED_MODE: begin
            ea_nxt = idxVal + {8'h00, memData}; // RULE_07
            eaReady = 1'b1;
          end
          opcode_decoder_pkg::PC_RELATIVE_MODE: begin
            if (taken) begin
              pc_nxt = relTarget; // RULE_08
              addr_nxt = relTarget;
            end
            done_nxt = 1'b1;
          end
          default: done_nxt = 1'b1;
        endcase
        if (eaReady && bitOp_r) begin
          st_nxt = opcode_decoder_pkg::S_MASK; // RULE_15
        end else if (eaReady) begin
          eaValid_nxt = 1'b1;
          done_nxt = 1'b1;
        end
      end
      opcode_decoder_pkg::S_OPERAND2: begin
        pc_nxt = pcStep;
        addr_nxt = pcStep;
        st_nxt = opcode_decoder_pkg::S_OPCODE;
        done_nxt = 1'b1;
        if (mode == opcode_decoder_pkg::IMMEDIATE_MODE) begin
          opr_nxt = {operand[15:8], memData}; // RULE_11
        end else begin
          ea_nxt = {operand[15:8], memData}; // RULE_12
          eaValid_nxt = 1'b1;
        end
      end
      opcode_decoder_pkg::S_MASK: begin
        pc_nxt = pcStep;
        mask_nxt = memData; // RULE_15
        eaValid_nxt = 1'b1;
        if (bitTest_r) begin
          addr_nxt = effectiveAddress;
          st_nxt = opcode_decoder_pkg::S_BIT_READ;
        end else begin
          addr_nxt = pcStep;
          done_nxt = 1'b1;
          st_nxt = opcode_decoder_pkg::S_OPCODE;
        end
      end
      opcode_decoder_pkg::S_BIT_READ: begin
        bitCond_nxt = bitSet_r ? ((~memData & mask) == 8'h00) : ((memData & mask) == 8'h00);
        mode_nxt = opcode_decoder_pkg::PC_RELATIVE_MODE;
        addr_nxt = pcOut;
        st_nxt = opcode_decoder_pkg::S_OPERAND1;
      end
      opcode_decoder_pkg::S_EXEC: begin
        cnt_nxt = cnt_r - 4'h1;
        if (cnt_r == 4'h1 && waitOp_r) begin
          st_nxt = opcode_decoder_pkg::S_WAIT; // RULE_03
        end else if (cnt_r == 4'h1) begin
          spLoad_nxt = 1'b1;
          done_nxt = 1'b1;
          st_nxt = opcode_decoder_pkg::S_OPCODE;
        end
      end
      opcode_decoder_pkg::S_WAIT: begin
        if (irqPending) begin
          cnt_nxt = opcode_decoder_pkg::VECTOR_CYCLES; // RULE_03
          addr_nxt = IRQ_VECTOR;
          st_nxt = opcode_decoder_pkg::S_VECTOR;
        end
      end
      opcode_decoder_pkg::S_VECTOR: begin
        cnt_nxt = cnt_r - 4'h1;
        addr_nxt = memAddr + 16'h0001;
        if (cnt_r == opcode_decoder_pkg::VECTOR_CYCLES) begin
          opr_nxt = {memData, 8'h00};
        end else begin
          pc_nxt = {operand[15:8], memData};
          addr_nxt = {operand[15:8], memData};
          waitOp_nxt = 1'b0;
          done_nxt = 1'b1;
          st_nxt = opcode_decoder_pkg::S_OPCODE;
        end
      end
    endcase
    if (done_nxt) begin
      page_nxt = opcode_decoder_pkg::PAGE_1;
    end
  end

  // sequencer state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= opcode_decoder_pkg::S_OPCODE;
      cnt_r <= 4'h0;
      {waitOp_r, wide_r, bitOp_r, bitTest_r, bitSet_r, bitCond_r} <= 6'h00;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      {waitOp_r, wide_r, bitOp_r, bitTest_r, bitSet_r, bitCond_r} <=
        {waitOp_nxt, wide_nxt, bitOp_nxt, bitTest_nxt, bitSet_nxt, bitCond_nxt};
    end
  end

  // registered outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {memAddr, pcOut, spOut} <= {opcode_decoder_pkg::RESET_PC, opcode_decoder_pkg::RESET_PC,
                                  opcode_decoder_pkg::RESET_SP};
      {operand, effectiveAddress, opcode, mask, page} <= 50'h0;
      mode <= opcode_decoder_pkg::IMPLIED_MODE;
      {memRead, eaValid, spLoad, instrDone, waitIdle, zeroPageInternal} <= 6'h20;
    end else begin
      {memAddr, pcOut, spOut} <= {addr_nxt, pc_nxt, sp_nxt};
      {operand, effectiveAddress, opcode, mask, page} <= {opr_nxt, ea_nxt, opc_nxt, mask_nxt, page_nxt};
      mode <= mode_nxt;
      memRead <= memRead_nxt;
      {eaValid, spLoad, instrDone} <= {eaValid_nxt, spLoad_nxt, done_nxt};
      waitIdle <= (st_nxt == opcode_decoder_pkg::S_WAIT);
      zeroPageInternal <= zp_nxt; // RULE_06
    end
  end

  // checks
  a_copy_x_sp: assert property (@(posedge clk) disable iff (!rst_n) // RULE_01
    (st_r == opcode_decoder_pkg::S_OPCODE && page == opcode_decoder_pkg::PAGE_1 &&
     memData == opcode_decoder_pkg::OP_COPY_TO_SP) |->
    ##3 (spLoad && instrDone && spOut == $past(xIn, 3) - 16'h0001))
    else $error("copy of X to stack pointer wrong");
  a_copy_y_sp: assert property (@(posedge clk) disable iff (!rst_n) // RULE_02
    (st_r == opcode_decoder_pkg::S_OPCODE && page == opcode_decoder_pkg::PAGE_2 &&
     memData == opcode_decoder_pkg::OP_COPY_TO_SP) |->
    ##3 (spLoad && spOut == $past(yIn, 3) - 16'h0001))
    else $error("copy of Y to stack pointer wrong");
  a_wait_stack: assert property (@(posedge clk) disable iff (!rst_n) // RULE_03
    (st_r == opcode_decoder_pkg::S_OPCODE && page == opcode_decoder_pkg::PAGE_1 &&
     memData == opcode_decoder_pkg::OP_WAIT) |->
    !waitIdle[*8] ##1 !waitIdle[*4] ##1 waitIdle)
    else $error("wait stacking not twelve cycles");
  a_wait_vector: assert property (@(posedge clk) disable iff (!rst_n) // RULE_03
    (st_r == opcode_decoder_pkg::S_WAIT && irqPending) |->
    ##1 (memAddr == IRQ_VECTOR && !instrDone) ##2 (instrDone && st_r == opcode_decoder_pkg::S_OPCODE))
    else $error("vector fetch not two cycles");
  a_direct_page: assert property (@(posedge clk) disable iff (!rst_n) // RULE_04
    (st_r == opcode_decoder_pkg::S_OPERAND1 && mode == opcode_decoder_pkg::DIRECT_MODE && !bitOp_r) |->
    ##1 (eaValid && effectiveAddress == {8'h00, $past(memData)}))
    else $error("direct address wrong");
  a_indexed_sum: assert property (@(posedge clk) disable iff (!rst_n) // RULE_07
    (st_r == opcode_decoder_pkg::S_OPERAND1 && mode == opcode_decoder_pkg::X_INDEXED_MODE && !useY) |->
    ##1 (effectiveAddress == $past(xIn) + {8'h00, $past(memData)}))
    else $error("indexed address wrong");
  a_branch_target: assert property (@(posedge clk) disable iff (!rst_n) // RULE_08
    (st_r == opcode_decoder_pkg::S_OPERAND1 && mode == opcode_decoder_pkg::PC_RELATIVE_MODE) |->
    ##1 (pcOut == ($past(taken) ? $past(relTarget) : $past(pcOut) + 16'h0001) && memAddr == pcOut))
    else $error("branch target wrong");
  a_wide_order: assert property (@(posedge clk) disable iff (!rst_n) // RULE_11
    (st_r == opcode_decoder_pkg::S_OPERAND1 && mode == opcode_decoder_pkg::IMMEDIATE_MODE && wide_r) |->
    ##2 (instrDone && operand == {$past(memData, 2), $past(memData)}))
    else $error("wide immediate order wrong");
  a_zero_page: assert property (@(posedge clk) disable iff (!rst_n) // RULE_06
    eaValid |-> (zeroPageInternal == (effectiveAddress[15:8] == 8'h00 && $past(zeroPageInternalEn))))
    else $error("zero page select wrong");
endmodule : opcode_addressing_decoder
`default_nettype wire

// file: test/program_memory_model.sv
// Purpose: program and data memory seen by the decoder over its read bus
// Assumes: read data is valid in the same cycle as the address
// Notes: the bench loads bytes straight into the array, code bytes while reset is held
`timescale 1ns/1ps
`default_nettype none
module program_memory_model (
  input wire logic clk,
  input wire logic [15:0] memAddr,
  input wire logic memRead,
  output logic [7:0] memData
);
  logic [7:0] bytes [0:65535];
  logic [7:0] lastByte;
  // a released bus shows the inverse of the last byte, never a stale copy
  assign memData = memRead ? bytes[memAddr] : ~lastByte;
  // remember the byte handed over at each read edge
  always @(posedge clk) begin
    if (memRead) begin
      lastByte <= bytes[memAddr];
    end
  end
  // empty memory reads as single-byte implied opcodes
  initial begin
    lastByte = 8'h00;
    for (int i = 0; i < 65536; i++) begin
      bytes[i] = 8'h01;
    end
  end
endmodule : program_memory_model
`default_nettype wire

// file: test/opcode_addressing_decoder_tb.sv
// Purpose: self-checking bench for the opcode and addressing decoder
// Assumes: each instruction is placed at address 0 and run from reset
// Notes: random operands come from a fixed-seed shift register
`timescale 1ns/1ps
`default_nettype none
module opcode_addressing_decoder_tb;
  logic clk, rst_n, branchCond, irqPending, zeroPageInternalEn, memRead, eaValid;
  logic spLoad, instrDone, waitIdle, zeroPageInternal, capZp, idle11, idle12;
  logic [15:0] xIn, yIn, memAddr, operand, effectiveAddress, spOut, pcOut;
  logic [15:0] capEa, capSp, capPc, capOp, hl;
  logic [7:0] memData, opcode, mask, capMask, d, m;
  logic [1:0] page;
  opcode_decoder_pkg::mode_e mode, capMode;
  logic [31:0] lfsrState = 32'h0001_2140;
  int fails = 0;
  int nTests = 0;
  int cyc, reads, dc, n;

  opcode_addressing_decoder dut (.clk(clk), .rst_n(rst_n), .memData(memData), .xIn(xIn),
    .yIn(yIn), .branchCond(branchCond), .irqPending(irqPending),
    .zeroPageInternalEn(zeroPageInternalEn), .memAddr(memAddr), .memRead(memRead),
    .opcode(opcode), .page(page), .mode(mode), .operand(operand),
    .effectiveAddress(effectiveAddress), .eaValid(eaValid), .mask(mask), .spOut(spOut),
    .spLoad(spLoad), .pcOut(pcOut), .instrDone(instrDone), .waitIdle(waitIdle),
    .zeroPageInternal(zeroPageInternal));

  program_memory_model mem (.clk(clk), .memAddr(memAddr), .memRead(memRead),
    .memData(memData));

  // shift register random source
  function automatic logic [31:0] rnd();
    lfsrState = {lfsrState[30:0], lfsrState[31] ^ lfsrState[21] ^ lfsrState[1] ^ lfsrState[0]};
    return lfsrState;
  endfunction : rnd

  // branch target seen from an opcode at address 0
  function automatic logic [15:0] target(input logic [7:0] rr, input logic taken);
    return taken ? 16'h0002 + {{8{rr[7]}}, rr} : 16'h0002;
  endfunction : target

  // bit-test branch at address 0: op, dd, mm, rr, so the offset base is 4
  function automatic logic [15:0] bitTarget(input logic [7:0] op, input logic [7:0] b,
                                            input logic [7:0] mk, input logic [7:0] rr);
    logic tk;
    tk = op[0] ? ((b & mk) == 8'h00) : ((~b & mk) == 8'h00);
    return target(rr, tk) + 16'h0002;
  endfunction : bitTarget

  // page-1 column to addressing mode
  function automatic opcode_decoder_pkg::mode_e colMode(input logic [3:0] col);
    if (col == 4'h4 || col == 4'h5) begin
      return opcode_decoder_pkg::IMPLIED_MODE;
    end
    case (col[1:0])
      2'h0: return col[3] ? opcode_decoder_pkg::IMMEDIATE_MODE : opcode_decoder_pkg::IMPLIED_MODE;
      2'h1: return opcode_decoder_pkg::DIRECT_MODE;
      2'h2: return opcode_decoder_pkg::X_INDEXED_MODE;
      default: return opcode_decoder_pkg::FULL_ADDRESS_MODE;
    endcase
  endfunction : colMode

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    nTests++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d mismatches %0d", nTests, fails);
    if (fails == 0 && nTests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test

  // load code at 0, pulse reset, then watch until the instruction completes
  task automatic run(input logic [31:0] code, input int irqAt);
    @(negedge clk);
    rst_n = 1'b0;
    irqPending = 1'b0;
    for (int i = 0; i < 4; i++) begin
      mem.bytes[i] = code[31 - 8 * i -: 8];
    end
    @(negedge clk);
    rst_n = 1'b1;
    cyc = 0;
    reads = 1;
    while (1) begin
      @(negedge clk);
      cyc++;
      if (eaValid) begin
        capEa = effectiveAddress;
        capZp = zeroPageInternal;
      end
      if (spLoad) begin
        capSp = spOut;
      end
      if (cyc == 11) begin
        idle11 = waitIdle;
      end
      if (cyc == 12) begin
        idle12 = waitIdle;
      end
      if (instrDone || cyc > 300) begin
        capMode = mode;
        capOp = operand;
        capMask = mask;
        capPc = pcOut;
        irqPending = 1'b0;
        if (cyc > 300) begin
          fails++;
        end
        break;
      end
      if (memRead) begin
        reads++;
      end
      irqPending = (irqAt > 0) && (cyc >= irqAt);
    end
  endtask : run

  // clock generator
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // watchdog against a hung sequencer
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    stop_test();
  end

  // main sequence
  initial begin
    rst_n = 1'b0;
    irqPending = 1'b0;
    branchCond = 1'b0;
    zeroPageInternalEn = 1'b0;
    xIn = 16'h0000;
    yIn = 16'h0000;
    repeat (5) @(negedge clk);
    mem.bytes[16'hFFF2] = 8'(rnd());
    mem.bytes[16'hFFF3] = 8'(rnd());
    for (int k = 0; k < 4; k++) begin
      xIn = (k == 0) ? 16'h0000 : 16'(rnd());
      yIn = (k == 0) ? 16'hFFFF : 16'(rnd());
      d = (k == 1) ? 8'hFF : 8'(rnd());
      m = 8'(rnd());
      hl = 16'(rnd());
      zeroPageInternalEn = d[0];
      run(32'h3500_0000, 0);
      check(16'(cyc), 16'h0003);
      check(capSp, xIn - 16'h0001);
      check(16'(reads), 16'h0001);
      run(32'h1835_0000, 0);
      check(16'(cyc), 16'h0004);
      check(capSp, yIn - 16'h0001);
      check({8'h00, opcode}, 16'h0035);
      check({14'h0000, page}, 16'(opcode_decoder_pkg::PAGE_1));
      run({8'h96, d, 16'h0000}, 0);
      check(capEa, {8'h00, d});
      check({15'h0000, capZp}, {15'h0000, zeroPageInternalEn});
      dc = cyc;
      run({8'hB6, hl, 8'h00}, 0);
      check(capEa, hl);
      check(16'(reads), 16'h0003);
      check({15'h0000, dc < cyc}, 16'h0001);
      run({8'hA6, d, 16'h0000}, 0);
      check(capEa, xIn + {8'h00, d});
      run({8'h18, 8'hA6, d, 8'h00}, 0);
      check(capEa, yIn + {8'h00, d});
      run({8'h86, d, 16'h0000}, 0);
      check({8'h00, capOp[7:0]}, {8'h00, d});
      check(16'(capMode), 16'(opcode_decoder_pkg::IMMEDIATE_MODE));
      run({8'hCC, hl, 8'h00}, 0);
      check(capOp, hl);
      run({8'h18, 8'hCE, hl}, 0);
      check(capOp, hl);
      check(16'(reads), 16'h0004);
      run({8'h14, d, m, 8'h00}, 0);
      check({8'h00, capMask}, {8'h00, m});
      check(capEa, {8'h00, d});
      d = (k == 0) ? 8'h80 : (k == 1) ? 8'h7F : 8'(rnd());
      branchCond = m[0];
      run({8'h26, d, 16'h0000}, 0);
      check(capPc, target(d, branchCond));
      run({8'h20, d, 16'h0000}, 0);
      check(capPc, target(d, 1'b1));
      run({8'h21, d, 16'h0000}, 0);
      check(capPc, target(d, 1'b0));
      mem.bytes[16'h0040] = (k == 0) ? m : (k == 1) ? ~m : hl[7:0];
      run({8'h12, 8'h40, m, d}, 0);
      check(capPc, bitTarget(8'h12, mem.bytes[16'h0040], m, d));
      run({8'h13, 8'h40, m, d}, 0);
      check(capPc, bitTarget(8'h13, mem.bytes[16'h0040], m, d));
      n = (k == 3) ? 1 + int'(m[3:0]) : k + 1;
      run(32'h3E00_0000, 11 + n);
      check(16'(cyc), 16'(14 + n));
      check({14'h0000, idle11, idle12}, 16'h0001);
      check(capPc, {mem.bytes[16'hFFF2], mem.bytes[16'hFFF3]});
    end
    for (int c = 4; c < 16; c++) begin
      run({4'(c), 4'h0, 24'(rnd())}, 0);
      check(16'(capMode), 16'(colMode(4'(c))));
    end
    stop_test();
  end
endmodule : opcode_addressing_decoder_tb
`default_nettype wire
